//--- logic/uart_pkg.sv
// Shared constants and types for the asynchronous serial transceiver
package uart_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses on the APB side)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TXDATA = 8'h04;
  localparam logic [7:0] OFF_RXDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_DIV = 8'h14;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_LEN_LSB = 0;
  localparam int CTRL_PAR_OFF = 2;
  localparam int CTRL_EVEN = 3;
  localparam int CTRL_STOP = 4;
  localparam int CMD_CLR_READY = 0;
  localparam int CMD_MCLR = 1;
  localparam int STAT_TBE = 0;
  localparam int STAT_TSE = 1;
  localparam int STAT_READY = 2;
  localparam int STAT_OVR = 3;
  localparam int STAT_FRM = 4;
  localparam int STAT_PAR = 5;
  localparam int DIV_TX_LSB = 0;
  localparam int DIV_RX_LSB = 16;

  // ------------------------------------------------------------------
  // Reset values and timing counts (in sample-clock ticks)
  // ------------------------------------------------------------------
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] DIV_RESET = 16'h000d;
  localparam logic [3:0] BIT_LAST_TICK = 4'hf;
  localparam logic [3:0] START_CENTER = 4'h7;
  localparam logic [5:0] STOP_ONE = 6'h10;
  localparam logic [5:0] STOP_ONE_HALF = 6'h18;
  localparam logic [5:0] STOP_TWO = 6'h20;
  localparam logic [5:0] MCLR_TICKS = 6'h12;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_CLEAR}
    tx_state_t;
  typedef enum {RX_HUNT, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

endpackage : uart_pkg

//--- logic/uart_cfg_if.sv
// Character format, master clear and sample tick handed to the transmitter
`timescale 1ns/10ps
interface uart_cfg_if;
  logic [1:0] len_sel;
  logic parity_off;
  logic even_parity_sel;
  logic stop_len_sel;
  logic master_clear;
  logic tick;
  modport source (output len_sel, parity_off, even_parity_sel,
    stop_len_sel, master_clear, tick);
  modport sink (input len_sel, parity_off, even_parity_sel,
    stop_len_sel, master_clear, tick);
endinterface : uart_cfg_if

//--- logic/tick_divider.sv
// Divider that makes the 16x sample-clock enable pulse
`timescale 1ns/10ps
module tick_divider #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Rate
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] last;

  // A zero divisor runs at the full clock rate rather than stalling
  assign last = (divisor == '0) ? '0 : divisor - WIDTH'(1);
  assign tick = (count >= last);

  // Wrap also when software shrinks the divisor below the count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (tick) begin
      count <= '0;
    end else begin
      count <= count + WIDTH'(1);
    end
  end
endmodule : tick_divider

//--- logic/tx_engine.sv
// Transmit holding buffer, shifter and frame sequencer
`timescale 1ns/10ps
module tx_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Format and timing
  uart_cfg_if.sink cfg,
  // Host side
  input wire logic load,
  input wire logic [7:0] load_data,
  output logic tx_buffer_empty,
  output logic tx_shift_empty,
  // Line
  output logic tx_serial_out
);
  import uart_pkg::*;

  tx_state_t state;
  logic [5:0] count;
  logic [2:0] bit_idx;
  logic [7:0] hold;
  logic [7:0] shift;
  logic par;
  logic take;
  logic bit_end;
  logic last_bit;
  logic [5:0] stop_len;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  // A load in the same cycle defers the move by one tick
  assign take = cfg.tick && state == TX_IDLE && !tx_buffer_empty && !load;
  assign bit_end = cfg.tick && count[3:0] == BIT_LAST_TICK;
  assign last_bit = bit_idx == 3'(3'h4 + {1'b0, cfg.len_sel});
  assign stop_len = !cfg.stop_len_sel ? STOP_ONE :
    (cfg.len_sel == 2'h0) ? STOP_ONE_HALF : STOP_TWO;
  assign tx_shift_empty = (state == TX_IDLE);

  // Holding buffer: load clears empty, the move into the shifter sets it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold <= 8'h00;
      tx_buffer_empty <= 1'b1;
    end else if (load) begin
      hold <= load_data;
      tx_buffer_empty <= 1'b0;
    end else if (take) begin
      tx_buffer_empty <= 1'b1;
    end
  end

  // Frame sequencer: start, data LSB first, parity, stop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= TX_IDLE;
      count <= 6'h00;
      bit_idx <= 3'h0;
      shift <= 8'h00;
      par <= 1'b0;
      tx_serial_out <= 1'b1;
    end else if (cfg.master_clear) begin
      state <= TX_CLEAR;
      count <= 6'h00;
      tx_serial_out <= 1'b1;
    end else if (cfg.tick) begin
      count <= count + 6'h01;
      case (state)
        TX_IDLE: begin
          if (take) begin
            state <= TX_START;
            shift <= hold;
            par <= !cfg.even_parity_sel;
            count <= 6'h00;
            tx_serial_out <= 1'b0;
          end
        end
        TX_START: begin
          if (bit_end) begin
            state <= TX_DATA;
            count <= 6'h00;
            bit_idx <= 3'h0;
            tx_serial_out <= shift[0];
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            count <= 6'h00;
            par <= par ^ shift[0];
            bit_idx <= bit_idx + 3'h1;
            shift <= {1'b0, shift[7:1]};
            tx_serial_out <= shift[1];
            if (last_bit && cfg.parity_off) begin
              state <= TX_STOP;
              tx_serial_out <= 1'b1;
            end else if (last_bit) begin
              state <= TX_PARITY;
              tx_serial_out <= par ^ shift[0];
            end
          end
        end
        TX_PARITY: begin
          if (bit_end) begin
            state <= TX_STOP;
            count <= 6'h00;
            tx_serial_out <= 1'b1;
          end
        end
        TX_STOP: begin
          if (count == stop_len - 6'h01) begin
            state <= TX_IDLE;
            count <= 6'h00;
          end
        end
        TX_CLEAR: begin
          if (count == MCLR_TICKS - 6'h01) begin
            state <= TX_IDLE;
            count <= 6'h00;
          end
        end
        default: begin
          state <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_load_clears_empty: assert property (
    @(posedge clk) disable iff (!arst_n) load |=> !tx_buffer_empty)
    else $error("buffer-empty not cleared by load");

  a_move_starts_frame: assert property (
    @(posedge clk) disable iff (!arst_n)
    take && !cfg.master_clear |=>
      !tx_serial_out && !tx_shift_empty && tx_buffer_empty)
    else $error("move into shifter did not start a frame");
endmodule : tx_engine

//--- logic/async_serial_transceiver.sv
// Asynchronous serial transceiver with APB register access
//
// Contract
// - A load captures the eight parallel transmit bits into the holding buffer.
// - Short characters send only the low bits; first input is the LSB.
// - Loading the buffer clears the buffer-empty flag.
// - Idle shifter takes the buffer within one tick, starts, sets empty.
// - Transmitter advances one bit per sixteen transmit ticks.
// - Reload while shifting waits, then follows end to end.
// - Receiver samples on a tick at sixteen times the bit rate.
// - Host clear forces the data-received flag low; here a set in the same cycle wins.
// - At the first stop bit the shift register moves to the holding word.
// - Short received words are right-justified, upper bits low.
// - Overrun rises when a move finds data-received still set.
// - One cycle after the move, data-received and framing update.
// - Parity flag high when received parity disagrees with setting.
// - Start centre at count 7 1/2; later bits sampled mid-bit.
// - Search for the next start resumes at the first stop centre.
// - Even or odd parity when enabled; inhibited means none, flag low.
// - Long stop gives 1.5 bits for five-bit, else two; short gives one.
// - Master clear drops flags; shifter empty 18 ticks after it falls.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
module async_serial_transceiver #(
  parameter int ADDR_W = 8,
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial line
  output logic TX_SERIAL_OUT,
  input wire logic RX_SERIAL_IN
);
  import uart_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  uart_cfg_if tx_if ();

  logic [4:0] ctrl;
  logic [DIV_W-1:0] tx_div;
  logic [DIV_W-1:0] rx_div;
  logic [31:0] read_mux;
  logic apb_setup;
  logic apb_write;
  logic known;
  logic wr_ctrl;
  logic wr_txdata;
  logic wr_cmd;
  logic wr_div;
  logic clr_ready;
  logic mclr;
  logic tx_load;
  logic tx_buffer_empty;
  logic tx_shift_empty;
  logic rx_tick;

  rx_state_t rx_state;
  logic [3:0] rx_count;
  logic [2:0] rx_idx;
  logic [7:0] rx_shift;
  logic rx_parity_bit;
  logic rx_mid;
  logic rx_last_bit;
  logic rx_move;
  logic rx_pending;
  logic stop_ok;
  logic parity_bad;
  logic next_parity_bad;
  logic [7:0] rx_holding_word;
  logic rx_char_ready;
  logic overrun_flag;
  logic framing_flag;
  logic parity_flag;

  // ------------------------------------------------------------------
  // Register address decode
  // ------------------------------------------------------------------
  // Only the six aligned words answer; everything else is an error
  function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
    reg_known = addr == ADDR_W'(OFF_CTRL) || addr == ADDR_W'(OFF_TXDATA)
      || addr == ADDR_W'(OFF_RXDATA) || addr == ADDR_W'(OFF_STATUS)
      || addr == ADDR_W'(OFF_CMD) || addr == ADDR_W'(OFF_DIV);
  endfunction : reg_known

  // Zero wait states: every access completes in its first access cycle
  assign apb_setup = PSEL && !PENABLE;
  assign apb_write = PSEL && PENABLE && PWRITE;
  assign known = reg_known(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !known;
  assign wr_ctrl = apb_write && PADDR == ADDR_W'(OFF_CTRL);
  assign wr_txdata = apb_write && PADDR == ADDR_W'(OFF_TXDATA);
  assign wr_cmd = apb_write && PADDR == ADDR_W'(OFF_CMD);
  assign wr_div = apb_write && PADDR == ADDR_W'(OFF_DIV);

  // Command strobes are single-cycle pulses, nothing is stored
  assign tx_load = wr_txdata;
  assign clr_ready = wr_cmd && PWDATA[CMD_CLR_READY];
  assign mclr = wr_cmd && PWDATA[CMD_MCLR];

  // ------------------------------------------------------------------
  // Control, divisor and read data registers
  // ------------------------------------------------------------------
  // Format is latched on the control write and held until the next one
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= PWDATA[4:0];
    end
  end

  // Both sample-clock rates come from one register
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_div <= DIV_W'(DIV_RESET);
      rx_div <= DIV_W'(DIV_RESET);
    end else if (wr_div) begin
      tx_div <= PWDATA[DIV_TX_LSB +: DIV_W];
      rx_div <= PWDATA[DIV_RX_LSB +: DIV_W];
    end
  end

  // Read data is captured in the setup cycle so it stands as a flop
  assign read_mux =
    (PADDR == ADDR_W'(OFF_CTRL)) ? {27'h0000000, ctrl} :
    (PADDR == ADDR_W'(OFF_RXDATA)) ? {24'h000000, rx_holding_word} :
    (PADDR == ADDR_W'(OFF_STATUS)) ? {26'h0000000, parity_flag,
      framing_flag, overrun_flag, rx_char_ready, tx_shift_empty,
      tx_buffer_empty} :
    (PADDR == ADDR_W'(OFF_DIV)) ? {rx_div, tx_div} : 32'h00000000;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
    end else if (apb_setup) begin
      PRDATA <= read_mux;
    end
  end

  // ------------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------------
  assign tx_if.len_sel = ctrl[CTRL_LEN_LSB +: 2];
  assign tx_if.parity_off = ctrl[CTRL_PAR_OFF];
  assign tx_if.even_parity_sel = ctrl[CTRL_EVEN];
  assign tx_if.stop_len_sel = ctrl[CTRL_STOP];
  assign tx_if.master_clear = mclr;

  tick_divider #(.WIDTH(DIV_W)) u_tx_rate (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .divisor(tx_div),
    .tick(tx_if.tick)
  );

  tx_engine u_tx (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .cfg(tx_if.sink),
    .load(tx_load),
    .load_data(PWDATA[7:0]),
    .tx_buffer_empty(tx_buffer_empty),
    .tx_shift_empty(tx_shift_empty),
    .tx_serial_out(TX_SERIAL_OUT)
  );

  // ------------------------------------------------------------------
  // Receiver timing
  // ------------------------------------------------------------------
  tick_divider #(.WIDTH(DIV_W)) u_rx_rate (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .divisor(rx_div),
    .tick(rx_tick)
  );

  // Mid-bit is the sixteenth tick after the previous centre
  assign rx_mid = rx_tick && rx_count == BIT_LAST_TICK;
  assign rx_last_bit = rx_idx == 3'(3'h4 + {1'b0, tx_if.len_sel});
  assign rx_move = rx_mid && rx_state == RX_STOP;
  assign next_parity_bad = !tx_if.parity_off &&
    ((^rx_shift) ^ rx_parity_bit ^ !tx_if.even_parity_sel);

  // ------------------------------------------------------------------
  // Receiver sequencer
  // ------------------------------------------------------------------
  // A glitch shorter than half a bit is taken as a false start
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_state <= RX_HUNT;
      rx_count <= 4'h0;
      rx_idx <= 3'h0;
      rx_shift <= 8'h00;
      rx_parity_bit <= 1'b0;
    end else if (mclr) begin
      rx_state <= RX_HUNT;
      rx_count <= 4'h0;
    end else if (rx_tick) begin
      rx_count <= rx_count + 4'h1;
      case (rx_state)
        RX_HUNT: begin
          if (!RX_SERIAL_IN) begin
            rx_state <= RX_START;
            rx_count <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_count == START_CENTER) begin
            rx_state <= RX_SERIAL_IN ? RX_HUNT : RX_DATA;
            rx_count <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= 8'h00;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shift[rx_idx] <= RX_SERIAL_IN;
            rx_idx <= rx_idx + 3'h1;
            if (rx_last_bit) begin
              rx_state <= tx_if.parity_off ? RX_STOP : RX_PARITY;
            end
          end
        end
        RX_PARITY: begin
          if (rx_mid) begin
            rx_parity_bit <= RX_SERIAL_IN;
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_state <= RX_HUNT;
          end
        end
        default: begin
          rx_state <= RX_HUNT;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Holding word and status flags
  // ------------------------------------------------------------------
  // The holding word survives master clear on purpose
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_holding_word <= 8'h00;
    end else if (rx_move && !mclr) begin
      rx_holding_word <= rx_shift;
    end
  end

  // Stop and parity results wait one cycle for the flag update
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_pending <= 1'b0;
      stop_ok <= 1'b1;
      parity_bad <= 1'b0;
    end else begin
      rx_pending <= rx_move && !mclr;
      if (rx_move) begin
        stop_ok <= RX_SERIAL_IN;
        parity_bad <= next_parity_bad;
      end
    end
  end

  // Set wins over the host clear; master clear beats everything
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_char_ready <= 1'b0;
      overrun_flag <= 1'b0;
      framing_flag <= 1'b0;
      parity_flag <= 1'b0;
    end else if (mclr) begin
      rx_char_ready <= 1'b0;
      overrun_flag <= 1'b0;
      framing_flag <= 1'b0;
      parity_flag <= 1'b0;
    end else begin
      if (rx_move) begin
        overrun_flag <= rx_char_ready && !clr_ready;
      end
      if (rx_pending) begin
        rx_char_ready <= 1'b1;
        framing_flag <= !stop_ok;
        parity_flag <= parity_bad;
      end else if (clr_ready) begin
        rx_char_ready <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_move;
    rx_move && !mclr;
  endsequence

  sequence s_flag_up;
    ##1 !rx_char_ready ##0 1'b1 ##1 rx_char_ready;
  endsequence

  a_ready_after_move: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_move ##1 !mclr |=> rx_char_ready && framing_flag == !stop_ok)
    else $error("data-received not set one cycle after move");

  a_move_resumes_hunt: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_move |=> rx_state == RX_HUNT)
    else $error("receiver not hunting after first stop centre");

  a_overrun_cause: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_move and !clr_ready |=> overrun_flag == $past(rx_char_ready))
    else $error("overrun flag does not follow prior data-received");

  a_host_clear: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    clr_ready && !rx_pending |=> !rx_char_ready)
    else $error("host clear did not drop data-received");

  a_false_start: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    rx_state == RX_START && rx_tick && rx_count == START_CENTER
      && RX_SERIAL_IN && !mclr |=> rx_state == RX_HUNT)
    else $error("start bit high at centre was not rejected");

  a_justify_five: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_move and (tx_if.len_sel == 2'h0) |=> rx_holding_word[7:5] == 3'h0)
    else $error("unused upper receive bits not low");

  a_parity_inhibit: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_move and tx_if.parity_off |=> ##1 !parity_flag)
    else $error("parity flag set while parity inhibited");

  a_mclr_flags: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    mclr |=> !rx_char_ready && !overrun_flag && !framing_flag
      && !parity_flag)
    else $error("master clear left a status flag set");
endmodule : async_serial_transceiver

//--- dv/serial_peer.sv
// Remote serial transceiver model: frame decoder and frame sender
`timescale 1ns/10ps
module serial_peer (
  // Clock and lines
  input wire logic clk,
  input wire logic line_in,
  output logic line_out,
  // Frame format
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic even
);
  int rx_q[$];
  int t_q[$];
  int v;
  initial line_out = 1'b1;
  // Decoder: start centre after eight cycles, then one sample per bit
  always begin
    @(negedge line_in);
    t_q.push_back(int'($time / 40));
    repeat (8) @(posedge clk);
    v = 0;
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge clk);
      if (i < nbits) v[i] = line_in;
      else if (par_en && i == nbits) v[8] = line_in;
      else begin
        v[9] = line_in;
        break;
      end
    end
    rx_q.push_back(v);
  end
  // One line level held for a number of cycles
  task automatic put(input bit b, input int len);
    line_out <= b;
    repeat (len) @(posedge clk);
  endtask : put
  // A short low stop provokes a framing fault; its tail may look like
  // a start, which the receiver rejects at the start-bit centre
  task automatic send(input int d, input bit bad_par, input bit bad_stop);
    int p;
    p = !even ^ bad_par;
    @(posedge clk);
    put(1'b0, 16);
    for (int i = 0; i < nbits; i++) begin
      p ^= d[i];
      put(d[i], 16);
    end
    if (par_en) put(p[0], 16);
    put(!bad_stop, bad_stop ? 10 : 16);
    line_out <= 1'b1;
  endtask : send
endmodule : serial_peer

//--- dv/async_serial_transceiver_tb_top.sv
// Self-checking testbench for the asynchronous serial transceiver
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module async_serial_transceiver_tb_top;
  import uart_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, txo, rxi, slv;
  logic [3:0] nb = 4'h5;
  logic pe = 1'b1, ev = 1'b0;
  int err_total = 0, cmp_count = 0, cyc = 0, seed = 55727;
  int exp_q[$], n, p, d, sw, gap, v;
  always #20 clk = ~clk;
  // Hang guard: the whole run needs roughly 4200 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      finish_test();
    end
  end
  async_serial_transceiver dut (.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TX_SERIAL_OUT(txo), .RX_SERIAL_IN(rxi));
  serial_peer peer (.clk(clk), .line_in(txo), .line_out(rxi), .nbits(nb),
    .par_en(pe), .even(ev));
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 255;
  endfunction : rnd
  // Expected frame: masked data, parity in bit 8, stop level in bit 9
  function automatic int model(int d, int n, int p, int even);
    int m;
    m = d & ((1 << n) - 1);
    return m | (p ? (($countones(m) + (even == 0)) % 2) << 8 : 0) | 1 << 9;
  endfunction : model
  // ---------------------------------------------------------------
  // APB master: setup, then access held until pready at an edge
  // ---------------------------------------------------------------
  // No limit of its own: a missing pready is caught by the hang guard
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input logic [7:0] a, input int e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rc
  task automatic wait_rx(input int cnt);
    for (int k = 0; k < 2000 && peer.rx_q.size() < cnt; k++) @(posedge clk);
  endtask : wait_rx
  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rc(OFF_STATUS, 32'h3, "status");
    rc(OFF_CTRL, 32'h0, "ctrl");
    rc(OFF_DIV, 32'h000d000d, "div");
    rc(8'h18, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, slv)
    apb(1'b1, OFF_DIV, 32'h00010001);
    $display("test reset done");
    // Every length, parity mode and stop length, with a back-to-back load
    for (int c = 0; c < 8; c++) begin
      n = 5 + c % 4;
      p = c % 4 != 3;
      sw = c < 4 ? 16 : n == 5 ? 24 : 32;
      nb <= 4'(n);
      pe <= 1'(p);
      ev <= c[0];
      apb(1'b1, OFF_CTRL, 32'(c % 4 | !p << 2 | c % 2 << 3 | c / 4 << 4));
      d = rnd();
      apb(1'b1, OFF_TXDATA, 32'(d));
      exp_q.push_back(d);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK("shift empty", 1'b0, rd[STAT_TSE])
      d = rnd();
      apb(1'b1, OFF_TXDATA, 32'(d));
      exp_q.push_back(d);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK("buf empty", 1'b0, rd[STAT_TBE])
      wait_rx(2);
      gap = peer.t_q[1] - peer.t_q[0] - 16 * (1 + n + p) - sw;
      `CHK("gap", 1'b1, gap inside {0, 1})
      repeat (2) begin
        d = exp_q.pop_front();
        v = peer.rx_q.pop_front();
        `CHK("frame", model(d, n, p, c % 2), v)
      end
      peer.t_q.delete();
      peer.send(d, 1'b0, 1'b0);
      rc(OFF_RXDATA, d & ((1 << n) - 1), "rxdata");
      rc(OFF_STATUS, 32'h7, "received");
      apb(1'b1, OFF_CMD, 32'h1);
      rc(OFF_STATUS, 32'h3, "cleared");
      $display("test format %0d done", c);
    end
    // Faults: overrun, parity and framing, then master clear
    nb <= 4'h5;
    pe <= 1'b1;
    ev <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h08);
    rc(OFF_CTRL, 32'h08, "ctrl");
    peer.send(8'h15, 1'b0, 1'b0);
    peer.send(8'h0a, 1'b1, 1'b0);
    rc(OFF_STATUS, 32'h2f, "overrun parity");
    peer.send(8'h1f, 1'b0, 1'b1);
    rc(OFF_STATUS, 32'h1f, "framing");
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("mclr flags", 4'h0, rd[5:2])
    `CHK("mclr shift", 1'b0, rd[STAT_TSE])
    repeat (20) @(posedge clk);
    rc(OFF_STATUS, 32'h3, "after clear");
    rc(OFF_RXDATA, 32'h1f, "kept");
    $display("test faults done");
    finish_test();
  end
endmodule : async_serial_transceiver_tb_top
